/* core/isr_status_top.sv */
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module isr_status_top (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [isr_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [isr_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [isr_pkg::STRB_W-1:0]  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [isr_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [isr_pkg::DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic                        ops_pending,
    input  wire logic                        error_queue_nonempty,
    input  wire logic                        output_pending_flag,
    input  wire logic                        output_queue_read,
    input  wire logic                        output_data_lost,
    input  wire logic                        parse_error_event,
    input  wire logic                        execution_fault_event,
    input  wire logic                        device_fault_event,
    input  wire logic                        output_on,
    input  wire logic                        calibrating,
    input  wire logic                        current_regulating,
    input  wire logic                        voltage_regulating,
    input  wire logic                        channel_one_summary,
    input  wire logic                        channel_two_summary,
    input  wire logic                        channel_three_summary,
    input  wire logic                        channel_one_questionable_event_summary,
    input  wire logic                        channel_two_questionable_event_summary,
    input  wire logic                        channel_three_questionable_event_summary,
    output logic [7:0]                       service_status_byte,
    output logic                             service_request_flag,
    output logic                             wait_pending_command
);
    typedef struct packed {
        logic [7:0]  sb;
        logic [7:0]  sef;
        logic [7:0]  sef_en;
        logic [7:0]  och;
        logic [7:0]  och_en;
        logic [7:0]  ost;
        logic [7:0]  ost_en;
        logic [15:0] qch;
        logic [15:0] qch_en;
        logic [7:0]  sre;
        logic        power_done;
        logic        done_armed;
        logic        wait_hold;
    } isr_regs_t;

    isr_regs_t s;
    isr_regs_t next_s;

    isr_reg_if rif ();

    isr_axil_slave u_slave (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .rif     (rif)
    );

    function automatic logic is_mapped(input logic [isr_pkg::ADDR_W-1:0] a);
        logic r;
        r = 1'h0;
        case (a)
            isr_pkg::OFF_STATUS_BYTE,
            isr_pkg::OFF_STD_EVENT,
            isr_pkg::OFF_STD_EVENT_EN,
            isr_pkg::OFF_RUN_CHAN,
            isr_pkg::OFF_RUN_CHAN_EN,
            isr_pkg::OFF_RUN_STATE,
            isr_pkg::OFF_RUN_STATE_EN,
            isr_pkg::OFF_SUSP_CHAN,
            isr_pkg::OFF_SUSP_CHAN_EN,
            isr_pkg::OFF_SRQ_EN,
            isr_pkg::OFF_CONTROL: r = 1'h1;
            default: r = 1'h0;
        endcase
        return r;
    endfunction

    function automatic logic any_enabled(input logic [15:0] ev, input logic [15:0] en);
        return |(ev & en);
    endfunction

    function automatic logic [15:0] merge16(
        input logic [15:0]                old,
        input logic [isr_pkg::DATA_W-1:0] wd,
        input logic [isr_pkg::STRB_W-1:0] be
    );
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    localparam int CH_W = isr_pkg::CH_NUM;
    logic                          wr_hit;
    logic                          rd_hit;
    logic [7:0]                    se_set;
    logic [7:0]                    och_set;
    logic [7:0]                    ost_set;
    logic [15:0]                   qch_set;
    logic [7:0]                    sb_core;
    logic [CH_W-1:0]               operation_event_summary_chan;
    logic [CH_W-1:0]               questionable_event_summary_chan;
    logic                          clear_all;
    logic                          clr_sef;
    logic                          clr_och;
    logic                          clr_ost;
    logic                          clr_qch;

    assign service_status_byte  = s.sb;
    assign service_request_flag = s.sb[isr_pkg::SB_SRQ];
    assign wait_pending_command = s.wait_hold;

    always_comb begin
        next_s    = s;
        rif.rdata = '0;
        rif.ok    = 1'h0;
        wr_hit    = rif.wr && is_mapped(rif.addr);
        rd_hit    = rif.rd && is_mapped(rif.addr);
        operation_event_summary_chan = {channel_three_summary, channel_two_summary, channel_one_summary};
        questionable_event_summary_chan = {channel_three_questionable_event_summary, channel_two_questionable_event_summary, channel_one_questionable_event_summary};

        // unmapped offsets answer with an error, mapped ones read or write
        if (rif.rd || rif.wr) begin
            rif.ok = is_mapped(rif.addr);
        end
        case (rif.addr)
            isr_pkg::OFF_STATUS_BYTE:   rif.rdata = 32'(s.sb);
            isr_pkg::OFF_STD_EVENT:     rif.rdata = 32'(s.sef);
            isr_pkg::OFF_STD_EVENT_EN:  rif.rdata = 32'(s.sef_en);
            isr_pkg::OFF_RUN_CHAN:      rif.rdata = 32'(s.och);
            isr_pkg::OFF_RUN_CHAN_EN:   rif.rdata = 32'(s.och_en);
            isr_pkg::OFF_RUN_STATE:     rif.rdata = 32'(s.ost);
            isr_pkg::OFF_RUN_STATE_EN:  rif.rdata = 32'(s.ost_en);
            isr_pkg::OFF_SUSP_CHAN:     rif.rdata = 32'(s.qch);
            isr_pkg::OFF_SUSP_CHAN_EN:  rif.rdata = 32'(s.qch_en);
            isr_pkg::OFF_SRQ_EN:        rif.rdata = 32'(s.sre);
            isr_pkg::OFF_CONTROL: begin
                rif.rdata[isr_pkg::CTL_DONE] = s.done_armed;
                rif.rdata[isr_pkg::CTL_WAIT] = s.wait_hold;
            end
            default: rif.rdata = '0;
        endcase

        clear_all = wr_hit && (rif.addr == isr_pkg::OFF_CONTROL)
                    && rif.strb[0] && rif.wdata[isr_pkg::CTL_CLEAR];
        clr_sef = clear_all || (rd_hit && rif.addr == isr_pkg::OFF_STD_EVENT);
        clr_och = clear_all || (rd_hit && rif.addr == isr_pkg::OFF_RUN_CHAN);
        clr_ost = clear_all || (rd_hit && rif.addr == isr_pkg::OFF_RUN_STATE);
        clr_qch = clear_all || (rd_hit && rif.addr == isr_pkg::OFF_SUSP_CHAN);

        se_set = '0;
        se_set[isr_pkg::SE_PWRUP] = !s.power_done;
        se_set[isr_pkg::SE_PARSE] = parse_error_event;
        se_set[isr_pkg::SE_EXEC]  = execution_fault_event;
        se_set[isr_pkg::SE_DEV]   = device_fault_event;
        // an empty read only counts when nothing is still being produced
        se_set[isr_pkg::SE_QMIS] = (output_queue_read && !output_pending_flag
                                    && !ops_pending) || output_data_lost;
        se_set[isr_pkg::SE_DONE] = s.done_armed && !ops_pending;

        och_set = 8'(operation_event_summary_chan) << isr_pkg::CH_BASE;
        ost_set = '0;
        ost_set[isr_pkg::OS_ON]  = output_on;
        ost_set[isr_pkg::OS_CAL] = calibrating;
        ost_set[isr_pkg::OS_CUR]  = current_regulating;
        ost_set[isr_pkg::OS_VOLT] = voltage_regulating;
        qch_set = 16'(questionable_event_summary_chan) << isr_pkg::CH_BASE;

        // set wins over a clear in the same cycle
        next_s.sef = ((s.sef & {8{!clr_sef}}) | se_set) & isr_pkg::SE_MASK;
        next_s.och = ((s.och & {8{!clr_och}}) | och_set) & isr_pkg::OCH_MASK;
        next_s.ost = ((s.ost & {8{!clr_ost}}) | ost_set) & isr_pkg::OST_MASK;
        next_s.qch = ((s.qch & {16{!clr_qch}}) | qch_set) & isr_pkg::QCH_MASK;
        next_s.power_done = 1'h1;

        if (wr_hit && rif.strb[0]) begin
            case (rif.addr)
                isr_pkg::OFF_STD_EVENT_EN:
                    next_s.sef_en = rif.wdata[7:0] & isr_pkg::SE_MASK;
                isr_pkg::OFF_RUN_CHAN_EN:
                    next_s.och_en = rif.wdata[7:0] & isr_pkg::OCH_MASK;
                isr_pkg::OFF_RUN_STATE_EN:
                    next_s.ost_en = rif.wdata[7:0] & isr_pkg::OST_MASK;
                isr_pkg::OFF_SRQ_EN:
                    next_s.sre = rif.wdata[7:0] & isr_pkg::SRE_MASK;
                default: begin
                end
            endcase
        end
        if (wr_hit && rif.addr == isr_pkg::OFF_SUSP_CHAN_EN) begin
            next_s.qch_en = merge16(s.qch_en, rif.wdata, rif.strb) & isr_pkg::QCH_MASK;
        end

        // completion request waits for the pending set seen from the next edge
        if (s.done_armed && !ops_pending) begin
            next_s.done_armed = 1'h0;
        end
        if (s.wait_hold && !ops_pending) begin
            next_s.wait_hold = 1'h0;
        end
        if (wr_hit && rif.addr == isr_pkg::OFF_CONTROL && rif.strb[0]) begin
            if (rif.wdata[isr_pkg::CTL_DONE]) begin
                next_s.done_armed = 1'h1;
            end
            if (rif.wdata[isr_pkg::CTL_WAIT]) begin
                next_s.wait_hold = 1'h1;
            end
        end

        sb_core = '0;
        sb_core[isr_pkg::SB_RUN]   = any_enabled(16'(s.ost), 16'(s.ost_en))
                                   | any_enabled(16'(s.och), 16'(s.och_en));
        sb_core[isr_pkg::SB_STDEV] = any_enabled(16'(s.sef), 16'(s.sef_en));
        sb_core[isr_pkg::SB_OUTQ]  = output_pending_flag;
        sb_core[isr_pkg::SB_SUSP]  = any_enabled(s.qch, s.qch_en);
        sb_core[isr_pkg::SB_ERRQ]  = error_queue_nonempty;
        sb_core[isr_pkg::SB_SRQ]   = any_enabled(16'(sb_core), 16'(s.sre));
        next_s.sb = sb_core & isr_pkg::SB_MASK;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

/* pkg/isr_pkg.sv */
`default_nettype none
package isr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    typedef logic [ADDR_W-1:0] isr_addr_t;

    localparam isr_addr_t OFF_STATUS_BYTE   = 8'h00;
    localparam isr_addr_t OFF_STD_EVENT     = 8'h04;
    localparam isr_addr_t OFF_STD_EVENT_EN  = 8'h08;
    localparam isr_addr_t OFF_RUN_CHAN      = 8'h0C;
    localparam isr_addr_t OFF_RUN_CHAN_EN   = 8'h10;
    localparam isr_addr_t OFF_RUN_STATE     = 8'h14;
    localparam isr_addr_t OFF_RUN_STATE_EN  = 8'h18;
    localparam isr_addr_t OFF_SUSP_CHAN     = 8'h1C;
    localparam isr_addr_t OFF_SUSP_CHAN_EN  = 8'h20;
    localparam isr_addr_t OFF_SRQ_EN        = 8'h24;
    localparam isr_addr_t OFF_CONTROL       = 8'h28;

    localparam int SB_RUN   = 7;
    localparam int SB_SRQ   = 6;
    localparam int SB_STDEV = 5;
    localparam int SB_OUTQ  = 4;
    localparam int SB_SUSP  = 3;
    localparam int SB_ERRQ  = 2;

    localparam int SE_PWRUP = 7;
    localparam int SE_PARSE = 5;
    localparam int SE_EXEC  = 4;
    localparam int SE_DEV   = 3;
    localparam int SE_QMIS  = 2;
    localparam int SE_DONE  = 0;

    localparam int OS_ON   = 3;
    localparam int OS_CAL  = 2;
    localparam int OS_CUR  = 1;
    localparam int OS_VOLT = 0;

    localparam int CH_BASE = 1;
    localparam int CH_NUM  = 3;

    localparam logic [7:0]  SB_MASK   = 8'hFC;
    localparam logic [7:0]  SRE_MASK  = 8'hBC;
    localparam logic [7:0]  SE_MASK   = 8'hBD;
    localparam logic [7:0]  OCH_MASK  = 8'h0E;
    localparam logic [7:0]  OST_MASK  = 8'h0F;
    localparam logic [15:0] QCH_MASK  = 16'h000E;

    localparam int CTL_DONE  = 0;
    localparam int CTL_WAIT  = 1;
    localparam int CTL_CLEAR = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        SL_IDLE   = 4'h1,
        SL_WRESP  = 4'h2,
        SL_RFETCH = 4'h4,
        SL_RRESP  = 4'h8
    } isr_slv_state_t;
endpackage
`default_nettype wire

/* pkg/isr_reg_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface isr_reg_if;
    logic                        wr;
    logic                        rd;
    logic [isr_pkg::ADDR_W-1:0]  addr;
    logic [isr_pkg::DATA_W-1:0]  wdata;
    logic [isr_pkg::STRB_W-1:0]  strb;
    logic [isr_pkg::DATA_W-1:0]  rdata;
    logic                        ok;
    modport bus  (output wr, rd, addr, wdata, strb, input rdata, ok);
    modport regs (input wr, rd, addr, wdata, strb, output rdata, ok);
endinterface
`default_nettype wire

/* core/isr_axil_slave.sv */
`timescale 1ns/10ps
`default_nettype none
module isr_axil_slave (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [isr_pkg::ADDR_W-1:0]  awaddr,
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [isr_pkg::DATA_W-1:0]  wdata,
    input  wire logic [isr_pkg::STRB_W-1:0]  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    output logic [1:0]                       bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    input  wire logic [isr_pkg::ADDR_W-1:0]  araddr,
    input  wire logic                        arvalid,
    output logic                             arready,
    output logic [isr_pkg::DATA_W-1:0]       rdata,
    output logic [1:0]                       rresp,
    output logic                             rvalid,
    input  wire logic                        rready,
    isr_reg_if.bus                           rif
);
    typedef struct packed {
        isr_pkg::isr_slv_state_t     state;
        logic                        aw_got;
        logic                        w_got;
        logic [isr_pkg::ADDR_W-1:0]  addr_w;
        logic [isr_pkg::ADDR_W-1:0]  addr_r;
        logic [isr_pkg::DATA_W-1:0]  wdata;
        logic [isr_pkg::STRB_W-1:0]  strb;
        logic [1:0]                  resp;
        logic [isr_pkg::DATA_W-1:0]  rdata;
    } isr_slv_t;

    isr_slv_t s;
    isr_slv_t next_s;

    // reads wait for a write half-taken on an earlier edge; a write whose AW or W is taken on the same edge as the read runs after it
    assign awready = (s.state == isr_pkg::SL_IDLE) && !s.aw_got;
    assign wready  = (s.state == isr_pkg::SL_IDLE) && !s.w_got;
    assign arready = (s.state == isr_pkg::SL_IDLE) && !s.aw_got && !s.w_got;
    assign bvalid  = (s.state == isr_pkg::SL_WRESP);
    assign rvalid  = (s.state == isr_pkg::SL_RRESP);
    assign bresp   = s.resp;
    assign rresp   = s.resp;
    assign rdata   = s.rdata;

    always_comb begin
        next_s    = s;
        rif.wr    = 1'h0;
        rif.rd    = 1'h0;
        rif.addr  = (s.state == isr_pkg::SL_RFETCH) ? s.addr_r : s.addr_w;
        rif.wdata = s.wdata;
        rif.strb  = s.strb;
        case (s.state)
            isr_pkg::SL_IDLE: begin
                if (awvalid && awready) begin
                    next_s.aw_got = 1'h1;
                    next_s.addr_w = awaddr;
                end
                if (wvalid && wready) begin
                    next_s.w_got = 1'h1;
                    next_s.wdata = wdata;
                    next_s.strb  = wstrb;
                end
                if (s.aw_got && s.w_got) begin
                    rif.wr        = 1'h1;
                    next_s.resp   = rif.ok ? isr_pkg::RESP_OKAY : isr_pkg::RESP_SLVERR;
                    next_s.aw_got = 1'h0;
                    next_s.w_got  = 1'h0;
                    next_s.state  = isr_pkg::SL_WRESP;
                end else if (arvalid && arready) begin
                    next_s.addr_r = araddr;
                    next_s.state  = isr_pkg::SL_RFETCH;
                end
            end
            isr_pkg::SL_RFETCH: begin
                rif.rd       = 1'h1;
                next_s.rdata = rif.rdata;
                next_s.resp  = rif.ok ? isr_pkg::RESP_OKAY : isr_pkg::RESP_SLVERR;
                next_s.state = isr_pkg::SL_RRESP;
            end
            isr_pkg::SL_WRESP: begin
                if (bready) begin
                    next_s.state = isr_pkg::SL_IDLE;
                end
            end
            isr_pkg::SL_RRESP: begin
                if (rready) begin
                    next_s.state = isr_pkg::SL_IDLE;
                end
            end
            default: begin
                next_s.state = isr_pkg::SL_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s       <= '0;
            s.state <= isr_pkg::SL_IDLE;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

/* tb/isr_status_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module isr_status_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        ops_pending,
    input wire logic        error_queue_nonempty,
    input wire logic        output_pending_flag,
    input wire logic [7:0]  service_status_byte,
    input wire logic        service_request_flag,
    input wire logic        wait_pending_command
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wait_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr == isr_pkg::OFF_CONTROL && s_axi_wdata[1] && s_axi_wstrb[0];
    endsequence
    sequence ops_held;
        ops_pending [*3];
    endsequence
    a_srq_tracks: assert property (service_request_flag == service_status_byte[6]
        && (!service_request_flag || (service_status_byte & 8'hBC) != 8'h00))
        else $error("service request differs from status summary");
    a_low_bits_zero: assert property (service_status_byte[1:0] == 2'h0)
        else $error("unused status bits set");
    a_outq_follows: assert property ($past(aresetn) |->
        service_status_byte[4] == $past(output_pending_flag))
        else $error("output pending bit wrong");
    a_errq_follows: assert property ($past(aresetn) |->
        service_status_byte[2] == $past(error_queue_nonempty))
        else $error("error queue bit wrong");
    a_wait_starts: assert property (wait_wr ##1 ops_held |-> wait_pending_command)
        else $error("wait not raised");
    a_wait_holds: assert property (wait_pending_command && ops_pending |=>
        wait_pending_command)
        else $error("wait dropped while busy");
    a_wait_ends: assert property (wait_pending_command && !ops_pending |->
        ##[1:2] !wait_pending_command)
        else $error("wait not released");
    a_rdata_upper: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 |->
        s_axi_rdata[31:16] == 16'h0000)
        else $error("read data upper bits set");
endmodule
bind isr_status_top isr_status_sva u_sva (.*);
`default_nettype wire

/* tb/isr_poll_host.sv */
`timescale 1ns/10ps
`default_nettype none
module isr_poll_host (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       service_request_flag,
    input wire logic [7:0] service_status_byte,
    output logic [7:0]     poll_byte
);
    // polls only on request, so last answer stays visible
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            poll_byte <= 8'h00;
        end else if (service_request_flag) begin
            poll_byte <= service_status_byte;
        end
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic aclk = 1'b0, aresetn = 1'b0, ops = 1'b0, eqn = 1'b0, opf = 1'b0, oqr = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] ev = 4'h0, ost = 4'h0;
    logic [2:0] och = 3'h0, qch = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, srq, waitc;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] sb, poll;
    int n_fail = 0, cmp_count = 0;
    isr_status_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ops_pending(ops),
        .error_queue_nonempty(eqn), .output_pending_flag(opf), .output_queue_read(oqr),
        .output_data_lost(ev[3]), .parse_error_event(ev[0]), .execution_fault_event(ev[1]),
        .device_fault_event(ev[2]), .output_on(ost[3]), .calibrating(ost[2]),
        .current_regulating(ost[1]), .voltage_regulating(ost[0]), .channel_one_summary(och[0]),
        .channel_two_summary(och[1]), .channel_three_summary(och[2]), .channel_one_questionable_event_summary(qch[0]),
        .channel_two_questionable_event_summary(qch[1]), .channel_three_questionable_event_summary(qch[2]), .service_status_byte(sb),
        .service_request_flag(srq), .wait_pending_command(waitc));
    isr_poll_host host (.aclk(aclk), .aresetn(aresetn), .service_request_flag(srq),
        .service_status_byte(sb), .poll_byte(poll));
    initial begin
        forever #5 aclk = ~aclk;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %0t got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        // each channel drops its valid at the edge that takes it
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge aclk); while (!bvalid);
        chk(bresp, isr_pkg::RESP_OKAY);
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        chk(rdata, e);
        chk(rresp, er);
        rready <= 1'b0;
    endtask
    task t_power;
        rd(isr_pkg::OFF_STD_EVENT, 32'h80, 2'h0);
        rd(isr_pkg::OFF_STD_EVENT, 32'h00, 2'h0);
        rd(8'h2C, 32'h00, isr_pkg::RESP_SLVERR);
        wr(isr_pkg::OFF_STD_EVENT_EN, 32'hFF);
        rd(isr_pkg::OFF_STD_EVENT_EN, 32'hBD, 2'h0);
        wr(isr_pkg::OFF_SRQ_EN, 32'hFF);
    endtask
    task t_events;
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk) ev <= 4'h1 << i;
            @(posedge aclk) ev <= 4'h0;
            repeat (3) @(posedge aclk);
            @(negedge aclk) chk(sb[5], 1'b1);
            chk({srq, poll[6]}, 2'h3);
            rd(isr_pkg::OFF_STD_EVENT, 32'h20 >> i, 2'h0);
            repeat (3) @(posedge aclk);
            @(negedge aclk) chk(sb[6:5], 2'h0);
        end
        wr(isr_pkg::OFF_STD_EVENT_EN, 32'h00);
        @(posedge aclk) ev <= 4'h4;
        @(posedge aclk) ev <= 4'h0;
        repeat (4) @(posedge aclk);
        @(negedge aclk) chk(sb[5], 1'b0);
        rd(isr_pkg::OFF_STD_EVENT, 32'h08, 2'h0);
    endtask
    task t_queues;
        // queue read while data waits must not raise a query error
        @(posedge aclk) {opf, eqn, oqr} <= 3'h7;
        @(posedge aclk) oqr <= 1'b0;
        @(posedge aclk);
        @(negedge aclk) chk(sb & 8'h14, 8'h14);
        rd(isr_pkg::OFF_STD_EVENT, 32'h00, 2'h0);
        @(posedge aclk) {opf, eqn, oqr} <= 3'h1;
        @(posedge aclk) oqr <= 1'b0;
        @(posedge aclk);
        @(negedge aclk) chk(sb & 8'h14, 8'h00);
        rd(isr_pkg::OFF_STD_EVENT, 32'h04, 2'h0);
    endtask
    task t_groups;
        wr(isr_pkg::OFF_RUN_CHAN_EN, 32'hFF);
        wr(isr_pkg::OFF_SUSP_CHAN_EN, 32'hFFFF);
        wr(isr_pkg::OFF_RUN_STATE_EN, 32'hFF);
        @(posedge aclk) begin
            och <= 3'h2; qch <= 3'h4; ost <= 4'h2;
        end
        repeat (3) @(posedge aclk);
        @(negedge aclk) chk({sb[7], sb[3]}, 2'h3);
        @(posedge aclk) begin
            och <= 3'h0; qch <= 3'h0; ost <= 4'h0;
        end
        repeat (2) @(posedge aclk);
        rd(isr_pkg::OFF_RUN_CHAN, 32'h04, 2'h0);
        rd(isr_pkg::OFF_SUSP_CHAN, 32'h0008, 2'h0);
        rd(isr_pkg::OFF_RUN_STATE, 32'h02, 2'h0);
    endtask
    task t_sync;
        @(posedge aclk) ops <= 1'b1;
        wr(isr_pkg::OFF_CONTROL, 32'h1);
        repeat (3) @(posedge aclk);
        rd(isr_pkg::OFF_STD_EVENT, 32'h00, 2'h0);
        @(posedge aclk) ops <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(isr_pkg::OFF_STD_EVENT, 32'h01, 2'h0);
        @(posedge aclk) ops <= 1'b1;
        wr(isr_pkg::OFF_CONTROL, 32'h2);
        repeat (4) @(posedge aclk);
        @(negedge aclk) chk(waitc, 1'b1);
        rd(isr_pkg::OFF_CONTROL, 32'h2, 2'h0);
        @(posedge aclk) ops <= 1'b0;
        repeat (3) @(posedge aclk);
        @(negedge aclk) chk(waitc, 1'b0);
        // clear-all must drop a latched device fault before any read
        @(posedge aclk) ev <= 4'h4;
        @(posedge aclk) ev <= 4'h0;
        wr(isr_pkg::OFF_CONTROL, 32'h4);
        rd(isr_pkg::OFF_STD_EVENT, 32'h00, 2'h0);
    endtask
    task conclude;
        if (n_fail == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_power();
        t_events();
        t_queues();
        t_groups();
        t_sync();
        conclude();
    end
    initial begin
        #100000;
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
